// File: rtl/uarw_rx_recovery.sv
`timescale 1ns/10ps
`default_nettype none
module uarw_rx_recovery #(
    parameter int DATA_BITS = uarw_pkg::DATA_BITS_DEF
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // sample tick and serial line
    input wire logic SAMPLE_TICK_IN,
    input wire logic RXD_IN,
    // power state
    input wire logic [2:0] SLEEP_MODE_IN,
    input wire logic OTHER_WAKE_IN,
    // register port
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    // power and interrupt
    output logic OSC_ON_OUT,
    output logic UART_CLK_EN_OUT,
    output logic SYS_WAKE_OUT,
    output logic IRQ_OUT,
    // recovered frame
    output logic [8:0] RX_DATA_OUT,
    output logic RX_VALID_OUT
);
    localparam int CNT_W_L = uarw_pkg::CNT_W;

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    logic rxd_s1_ff, rxd_s2_ff, rxd_s3_ff, rxd_ff;
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_s3_ff <= 1'b1;
            rxd_ff <= 1'b1;
        end
        else
        begin
            rxd_s1_ff <= RXD_IN;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_s3_ff <= rxd_s2_ff;
            if (rxd_s2_ff == rxd_s3_ff)
                rxd_ff <= rxd_s3_ff;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic [7:0] ctrl_ff;
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            ctrl_ff <= uarw_pkg::CTRL_RST;
        else if (WR_IN && ADDR_IN == uarw_pkg::ADDR_CTRL)
            ctrl_ff <= WDATA_IN;
    end
    logic dbl, wake_en, par_en, rx_en;
    assign dbl = ctrl_ff[uarw_pkg::CTRL_DBL];
    assign wake_en = ctrl_ff[uarw_pkg::CTRL_WAKE];
    assign par_en = ctrl_ff[uarw_pkg::CTRL_PAR];
    assign rx_en = ctrl_ff[uarw_pkg::CTRL_EN];

    // ----------------------------------------
    // sample geometry
    // ----------------------------------------
    logic [CNT_W_L-1:0] vote_first, vote_last, spb;
    always_comb
    begin
        if (dbl)
        begin
            vote_first = CNT_W_L'(uarw_pkg::DBL_VOTE_FIRST);
            spb = CNT_W_L'(uarw_pkg::DBL_SPB);
        end
        else
        begin
            vote_first = CNT_W_L'(uarw_pkg::NORM_VOTE_FIRST);
            spb = CNT_W_L'(uarw_pkg::NORM_SPB);
        end
        vote_last = vote_first + CNT_W_L'(2);
    end

    // ----------------------------------------
    // bit recovery
    // ----------------------------------------
    uarw_pkg::uarw_state_t state_ff;
    logic [CNT_W_L-1:0] samp_ff;
    logic [1:0] lows_ff;
    logic [3:0] bit_ff;
    logic [8:0] shift_ff;
    logic prev_ff;
    logic done_ff;
    logic stop_low_ff;
    logic start_ok_ff;
    logic [3:0] nbits;
    logic vote_low;
    logic busy;
    logic step;
    logic vote_end;
    logic in_vote;
    logic last_bit;
    logic fall;
    assign nbits = 4'(DATA_BITS + (par_en ? 1 : 0));
    assign vote_low = (lows_ff + (rxd_ff ? 2'h0 : 2'h1)) >= 2'h2;
    assign busy = state_ff != uarw_pkg::ST_IDLE;
    assign step = rx_en && SAMPLE_TICK_IN;
    assign vote_end = step && busy && samp_ff == vote_last;
    assign in_vote = samp_ff >= vote_first && samp_ff < vote_last;
    assign last_bit = state_ff == uarw_pkg::ST_BITS && bit_ff == nbits;
    assign fall = prev_ff && !rxd_ff;

    // previous line level for edge detection
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            prev_ff <= 1'b1;
        else if (!rx_en)
            prev_ff <= 1'b1;
        else if (vote_end && last_bit)
            prev_ff <= 1'b1;
        else if (SAMPLE_TICK_IN)
            prev_ff <= rxd_ff;
    end

    // sample counter, vote tally and bit shifter
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            state_ff <= uarw_pkg::ST_IDLE;
            samp_ff <= uarw_pkg::CNT_ZERO;
            lows_ff <= 2'h0;
            bit_ff <= 4'h0;
            shift_ff <= 9'h000;
        end
        else if (!rx_en)
            state_ff <= uarw_pkg::ST_IDLE;
        else if (SAMPLE_TICK_IN)
        begin
            case (state_ff)
                uarw_pkg::ST_IDLE:
                begin
                    if (fall)
                    begin
                        state_ff <= uarw_pkg::ST_QUAL;
                        samp_ff <= uarw_pkg::CNT_ONE;
                        lows_ff <= 2'h0;
                    end
                end
                uarw_pkg::ST_QUAL, uarw_pkg::ST_BITS:
                begin
                    samp_ff <= samp_ff + uarw_pkg::CNT_ONE;
                    if (in_vote)
                        lows_ff <= lows_ff + (rxd_ff ? 2'h0 : 2'h1);
                    if (samp_ff == vote_last)
                    begin
                        lows_ff <= 2'h0;
                        if (state_ff == uarw_pkg::ST_QUAL)
                        begin
                            if (vote_low)
                            begin
                                state_ff <= uarw_pkg::ST_BITS;
                                bit_ff <= 4'h0;
                            end
                            else
                                state_ff <= uarw_pkg::ST_IDLE;
                        end
                        else if (last_bit)
                            state_ff <= uarw_pkg::ST_IDLE;
                        else
                        begin
                            shift_ff <= {~vote_low, shift_ff[8:1]};
                            bit_ff <= bit_ff + 4'h1;
                        end
                    end
                    if (samp_ff == spb)
                        samp_ff <= uarw_pkg::CNT_ONE;
                end
                default:
                    state_ff <= uarw_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // frame event pulses
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            start_ok_ff <= 1'b0;
        else
            start_ok_ff <= vote_end && state_ff == uarw_pkg::ST_QUAL && vote_low;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            done_ff <= 1'b0;
        else
            done_ff <= vote_end && last_bit;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            stop_low_ff <= 1'b0;
        else if (vote_end && last_bit)
            stop_low_ff <= vote_low;
    end

    // ----------------------------------------
    // receive buffer and flags
    // ----------------------------------------
    logic rd_stat, rd_data, rd_ctrl, wr_stat;
    assign rd_stat = RD_IN && ADDR_IN == uarw_pkg::ADDR_STATUS;
    assign rd_data = RD_IN && ADDR_IN == uarw_pkg::ADDR_DATA;
    assign rd_ctrl = RD_IN && ADDR_IN == uarw_pkg::ADDR_CTRL;
    assign wr_stat = WR_IN && ADDR_IN == uarw_pkg::ADDR_STATUS;
    logic rxc_ff, start_flag_ff, framing_fault_flag_ff;
    logic [8:0] rx_buf_ff;
    logic det_active;
    logic [8:0] frame_data;
    assign frame_data = par_en ? shift_ff : (shift_ff >> 1);
    // receive buffer loaded at frame end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            rx_buf_ff <= 9'h000;
        else if (done_ff)
            rx_buf_ff <= frame_data;
    end
    // rx done flag, set wins over read clear
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            rxc_ff <= 1'b0;
        else if (done_ff)
            rxc_ff <= 1'b1;
        else if (rd_data)
            rxc_ff <= 1'b0;
    end
    // start seen flag, set wins over write-one clear
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            start_flag_ff <= 1'b0;
        else if (start_ok_ff && det_active)
            start_flag_ff <= 1'b1;
        else if (wr_stat && WDATA_IN[uarw_pkg::ST_START])
            start_flag_ff <= 1'b0;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            framing_fault_flag_ff <= 1'b0;
        else if (done_ff)
            framing_fault_flag_ff <= stop_low_ff;
    end

    // ----------------------------------------
    // start frame detection and power
    // ----------------------------------------
    logic deep;
    assign deep = SLEEP_MODE_IN == uarw_pkg::SLP_PSAVE
               || SLEEP_MODE_IN == uarw_pkg::SLP_STBY
               || SLEEP_MODE_IN == uarw_pkg::SLP_ESTBY
               || SLEEP_MODE_IN == uarw_pkg::SLP_PDOWN;
    assign det_active = wake_en && rx_en && deep;
    logic pdown;
    assign pdown = SLEEP_MODE_IN == uarw_pkg::SLP_PDOWN;
    logic keep_clk;
    assign keep_clk = det_active && !pdown && (!rxd_ff || busy);
    logic rxc_ie, st_ie, irq_src;
    assign rxc_ie = ctrl_ff[uarw_pkg::CTRL_RXC_IE];
    assign st_ie = ctrl_ff[uarw_pkg::CTRL_START_IE];
    assign irq_src = (st_ie && start_flag_ff)
        || (rxc_ie && rxc_ff);

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    // oscillator request; power down never starts it
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            OSC_ON_OUT <= 1'b0;
        else if (!det_active)
            OSC_ON_OUT <= 1'b0;
        else if (pdown)
            OSC_ON_OUT <= 1'b0;
        else if (!rxd_ff || busy)
            OSC_ON_OUT <= 1'b1;
        else if (!OTHER_WAKE_IN)
            OSC_ON_OUT <= 1'b0;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            UART_CLK_EN_OUT <= 1'b0;
        else
            UART_CLK_EN_OUT <= !deep || OTHER_WAKE_IN
                || keep_clk;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            SYS_WAKE_OUT <= 1'b0;
        else
            SYS_WAKE_OUT <= det_active && irq_src;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            IRQ_OUT <= 1'b0;
        else
            IRQ_OUT <= irq_src;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            RX_VALID_OUT <= 1'b0;
        else
            RX_VALID_OUT <= done_ff;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            RX_DATA_OUT <= 9'h000;
        else if (done_ff)
            RX_DATA_OUT <= frame_data;
    end
    // read data stands one cycle after the strobe
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            RDATA_OUT <= 8'h00;
        else if (rd_stat)
            RDATA_OUT <= {5'h00, framing_fault_flag_ff, start_flag_ff, rxc_ff};
        else if (rd_data)
            RDATA_OUT <= rx_buf_ff[7:0];
        else if (rd_ctrl)
            RDATA_OUT <= ctrl_ff;
        else
            RDATA_OUT <= 8'h00;
    end
endmodule
`default_nettype wire

// File: rtl/uarw_pkg.sv
package uarw_pkg;
    // ----------------------------------------
    // sampling geometry
    // ----------------------------------------
    localparam int NORM_SPB = 16;
    localparam int DBL_SPB = 8;
    localparam int NORM_VOTE_FIRST = 8;
    localparam int DBL_VOTE_FIRST = 4;
    localparam int DATA_BITS_DEF = 8;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    // ----------------------------------------
    // sleep mode encodings
    // ----------------------------------------
    localparam logic [2:0] SLP_ACTIVE = 3'h0;
    localparam logic [2:0] SLP_IDLE = 3'h1;
    localparam logic [2:0] SLP_PDOWN = 3'h2;
    localparam logic [2:0] SLP_PSAVE = 3'h3;
    localparam logic [2:0] SLP_STBY = 3'h6;
    localparam logic [2:0] SLP_ESTBY = 3'h7;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_DATA = 4'h2;
    localparam int CTRL_DBL = 0;
    localparam int CTRL_WAKE = 1;
    localparam int CTRL_RXC_IE = 2;
    localparam int CTRL_START_IE = 3;
    localparam int CTRL_PAR = 4;
    localparam int CTRL_EN = 5;
    localparam int ST_RXC = 0;
    localparam int ST_START = 1;
    localparam int ST_FRAME = 2;
    localparam logic [7:0] CTRL_RST = 8'h20;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_QUAL = 2'b01,
        ST_BITS = 2'b10
    } uarw_state_t;
endpackage

// File: tb/uarw_rx_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// port checker
// --------
module uarw_rx_asserts (
    // clock, reset, inputs
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic SAMPLE_TICK_IN,
    input wire logic RXD_IN,
    input wire logic [2:0] SLEEP_MODE_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    // outputs
    input wire logic [7:0] RDATA_OUT,
    input wire logic OSC_ON_OUT,
    input wire logic IRQ_OUT,
    input wire logic RX_VALID_OUT
);
    logic [5:0] ctrl_ff;
    logic deep;
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    assign deep = SLEEP_MODE_IN inside {uarw_pkg::SLP_PSAVE,
        uarw_pkg::SLP_STBY, uarw_pkg::SLP_ESTBY};
    // shadow of the control register
    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
        if (!RST_B_IN)
            ctrl_ff <= uarw_pkg::CTRL_RST[5:0];
        else if (WR_IN && ADDR_IN == uarw_pkg::ADDR_CTRL)
            ctrl_ff <= WDATA_IN[5:0];
    a_rdata_quiet: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data outside read");
    a_rdata_unmapped: assert property ($past(RD_IN) && $past(ADDR_IN) > 4'h2
        |-> RDATA_OUT == 8'h00) else $error("unmapped read not zero");
    a_ctrl_readback: assert property ($past(RD_IN) && $past(ADDR_IN) == 4'h0
        |-> RDATA_OUT[5:0] == $past(ctrl_ff)) else $error("ctrl readback");
    a_valid_pulse: assert property (RX_VALID_OUT |=> !RX_VALID_OUT)
        else $error("valid longer than one cycle");
    a_valid_tick: assert property (RX_VALID_OUT |-> $past(SAMPLE_TICK_IN)
        || $past(SAMPLE_TICK_IN, 2)) else $error("valid not after tick");
    a_awake_no_osc: assert property (
        (SLEEP_MODE_IN inside {3'h0, 3'h1})[*4] |-> !OSC_ON_OUT)
        else $error("osc on in active or idle");
    a_pdown_no_osc: assert property (
        (SLEEP_MODE_IN == uarw_pkg::SLP_PDOWN)[*4] |-> !OSC_ON_OUT)
        else $error("osc on in power down");
    a_wake_off_osc: assert property (
        (!ctrl_ff[uarw_pkg::CTRL_WAKE])[*4] |-> !OSC_ON_OUT)
        else $error("osc on without wake enable");
    a_edge_osc: assert property (
        ctrl_ff[uarw_pkg::CTRL_WAKE] && ctrl_ff[uarw_pkg::CTRL_EN]
        && deep && $fell(RXD_IN)
        |-> ##[1:8] OSC_ON_OUT) else $error("edge did not power osc");
    a_irq_masked: assert property (
        (!ctrl_ff[2] && !ctrl_ff[3])[*2] |-> !IRQ_OUT)
        else $error("irq with both enables off");
endmodule
bind uarw_rx_recovery uarw_rx_asserts chk_i (.REF_CLK_IN, .RST_B_IN,
    .SAMPLE_TICK_IN, .RXD_IN, .SLEEP_MODE_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
    .RD_IN, .RDATA_OUT, .OSC_ON_OUT, .IRQ_OUT, .RX_VALID_OUT);
`default_nettype wire

// File: tb/uarw_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// remote serial transmitter
// --------
module uarw_tx_model (
    // clock and control
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic tick_in,
    input wire logic go_in,
    input wire logic dbl_in,
    input wire logic glitch_in,
    input wire logic stop_in,
    input wire logic [7:0] byte_in,
    // line side
    output logic txd_out,
    output logic busy_out
);
    logic [9:0] frm_ff;
    int smp_ff;
    int bit_ff;
    int spb;
    assign spb = dbl_in ? uarw_pkg::DBL_SPB : uarw_pkg::NORM_SPB;
    // exact bit time; optional one-sample glitch mid data bit 3
    assign txd_out = !busy_out ? 1'b1 : frm_ff[bit_ff] ^
        (glitch_in && bit_ff == 4 && smp_ff == spb / 2);
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in)
            busy_out <= 1'b0;
        else if (go_in && !busy_out)
        begin
            busy_out <= 1'b1;
            frm_ff <= {stop_in, byte_in, 1'b0};
            smp_ff <= 0;
            bit_ff <= 0;
        end
        else if (busy_out && tick_in)
        begin
            smp_ff <= (smp_ff == spb - 1) ? 0 : smp_ff + 1;
            if (smp_ff == spb - 1)
            begin
                bit_ff <= bit_ff + 1;
                busy_out <= (bit_ff != 9);
            end
        end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 0, rst_b = 0, tick = 0, wr = 0, rd = 0, go = 0, stp = 1;
    logic dbl = 0, glitch = 0, spike = 0, busy, txd, osc, irq, wake, rxv;
    logic clken;
    logic [1:0] tcnt = 0;
    logic [2:0] mode = 0;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, b = 0, v, rdata;
    logic [8:0] rx_data;
    logic [2:0] modes [3] = '{3'h3, 3'h6, 3'h7};
    int err_total = 0, compares = 0, nv = 0, no = 0, nw = 0, i, o, w;
    int nc = 0, c;
    uarw_rx_recovery dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
        .SAMPLE_TICK_IN(tick), .RXD_IN(txd & !spike), .SLEEP_MODE_IN(mode),
        .OTHER_WAKE_IN(1'b0), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .OSC_ON_OUT(osc),
        .UART_CLK_EN_OUT(clken), .SYS_WAKE_OUT(wake), .IRQ_OUT(irq),
        .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rxv));
    uarw_tx_model tx (.clk_in(clk), .rst_b_in(rst_b), .tick_in(tick),
        .go_in(go), .dbl_in(dbl), .glitch_in(glitch), .stop_in(stp),
        .byte_in(b), .txd_out(txd), .busy_out(busy));
    initial
        forever #10 clk = !clk;
    always @(posedge clk)
    begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
        nv <= nv + int'(rxv);
        no <= no + int'(osc);
        nw <= nw + int'(wake);
        nc <= nc + int'(clken);
    end
    task automatic chk(input string nm, input logic [8:0] e, g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w_en, input logic [3:0] a,
        input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w_en;
        rd <= !w_en;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        #1 v = rdata;
    endtask
    task automatic frame(input logic [7:0] d, input logic s);
        int n;
        while (busy !== 1'b0) @(negedge clk);
        repeat (100) @(posedge clk);
        @(posedge clk);
        b <= d;
        stp <= s;
        go <= 1;
        @(posedge clk);
        go <= 0;
        for (n = 0; n < 3000 && rxv !== 1'b1; n++) @(negedge clk);
        chk("rx valid", 1, rxv);
        chk("rx data", d, rx_data[7:0]);
        bus(0, uarw_pkg::ADDR_STATUS, 0);
        chk("status", {!s, 1'b1}, {v[2], v[0]});
        bus(0, uarw_pkg::ADDR_DATA, 0);
        chk("data reg", d, v);
    endtask
    task automatic noise();
        o = nv;
        @(posedge clk);
        spike <= 1;
        repeat (12) @(posedge clk);
        spike <= 0;
        repeat (700) @(posedge clk);
        chk("noise frames", 0, 9'(nv - o));
        chk("osc after noise", 0, osc);
    endtask
    task automatic final_report();
        $display("err_total %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        err_total++;
        final_report();
    end
    initial
    begin
        void'($urandom(32'h60b2e0a8));
        repeat (12) @(posedge clk);
        rst_b <= 1;
        bus(0, uarw_pkg::ADDR_CTRL, 0);
        chk("ctrl reset", 8'h20, v);
        bus(0, 4'hf, 0);
        chk("unmapped", 0, v);
        frame(8'h00, 1);
        frame(8'hff, 1);
        for (i = 0; i < 6; i++) frame(8'($urandom), 1);
        glitch <= 1;
        frame(8'h5a, 1);
        frame(8'($urandom), 0);
        glitch <= 0;
        noise();
        bus(1, uarw_pkg::ADDR_CTRL, 8'h21);
        dbl <= 1;
        glitch <= 1;
        for (i = 0; i < 4; i++) frame(8'($urandom), i[0]);
        glitch <= 0;
        dbl <= 0;
        bus(1, uarw_pkg::ADDR_CTRL, 8'h2a);
        for (i = 0; i < 3; i++)
        begin
            mode <= modes[i];
            o = no;
            w = nw;
            c = nc;
            frame(8'($urandom), 1);
            chk("osc seen", 1, 9'(no > o));
            chk("clk en seen", 1, 9'(nc > c));
            chk("wake seen", 1, 9'(nw > w));
            chk("irq start", 1, irq);
            bus(0, uarw_pkg::ADDR_STATUS, 0);
            chk("start seen", 1, v[1]);
            bus(1, uarw_pkg::ADDR_STATUS, 8'h02);
            bus(0, uarw_pkg::ADDR_STATUS, 0);
            chk("irq cleared", 0, irq);
        end
        mode <= uarw_pkg::SLP_PSAVE;
        noise();
        chk("clk en idle", 0, clken);
        bus(1, uarw_pkg::ADDR_CTRL, 8'h20);
        mode <= uarw_pkg::SLP_PDOWN;
        repeat (20) @(posedge clk);
        mode <= uarw_pkg::SLP_ACTIVE;
        frame(8'($urandom), 1);
        final_report();
    end
endmodule
`default_nettype wire
